// ### logic/mmu_fault_pkg.sv
package mmu_fault_pkg;

    // fault status codes, highest priority first
    localparam logic [3:0] FS_NONE = 4'h0;
    localparam logic [3:0] FS_ALIGN = 4'h1;
    localparam logic [3:0] FS_EXT_L1 = 4'hC;
    localparam logic [3:0] FS_EXT_L2 = 4'hE;
    localparam logic [3:0] FS_TRANS_SEC = 4'h5;
    localparam logic [3:0] FS_TRANS_PAGE = 4'h7;
    localparam logic [3:0] FS_DOM_SEC = 4'h9;
    localparam logic [3:0] FS_DOM_PAGE = 4'hB;
    localparam logic [3:0] FS_PERM_SEC = 4'hD;
    localparam logic [3:0] FS_PERM_PAGE = 4'hF;
    localparam logic [3:0] FS_LINE_SEC = 4'h4;
    localparam logic [3:0] FS_LINE_PAGE = 4'h6;
    localparam logic [3:0] FS_NCNB_SEC = 4'h8;
    localparam logic [3:0] FS_NCNB_PAGE = 4'hA;

    // domain access field values
    localparam logic [1:0] DOM_NO_ACCESS = 2'h0;
    localparam logic [1:0] DOM_CLIENT = 2'h1;
    localparam logic [1:0] DOM_RESERVED = 2'h2;
    localparam logic [1:0] DOM_MANAGER = 2'h3;

    // descriptor type field, bits 1..0
    localparam logic [1:0] DESC_INVALID = 2'h0;
    localparam logic [1:0] L1_COARSE = 2'h1;
    localparam logic [1:0] L1_SECTION = 2'h2;
    localparam logic [1:0] L1_FINE = 2'h3;
    localparam logic [1:0] L2_LARGE = 2'h1;
    localparam logic [1:0] L2_SMALL = 2'h2;
    localparam logic [1:0] L2_TINY = 2'h3;

    // system control word bit positions
    localparam int CTRL_MMU_BIT = 0;
    localparam int CTRL_ALIGN_BIT = 1;
    localparam int CTRL_SYS_BIT = 8;
    localparam int CTRL_ROM_BIT = 9;

    // descriptor field positions
    localparam int L1_DOMAIN_LSB = 5;
    localparam int L1_AP_LSB = 10;
    localparam int L2_AP_LSB = 4;

    // default cache line length in words
    localparam int LINE_WORDS_DEFAULT = 8;

    typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} size_t;

    typedef enum {ST_IDLE, ST_L1, ST_L2, ST_BUS, ST_SWAP_WR} state_t;

    typedef struct packed {
        logic [31:0] va;
        size_t size;
        logic write;
        logic fetch;
        logic user;
        logic swap;
        logic linefill;
    } acc_req_t;

endpackage

// ### logic/perm_decode.sv
`timescale 1ns/1ns
module perm_decode
    import mmu_fault_pkg::*;
(
    // permission query
    input wire logic [1:0] ap,
    input wire logic sys_prot,
    input wire logic rom_prot,
    input wire logic user,
    input wire logic write,
    // answer
    output logic allow
);
    always_comb begin
        allow = 1'b0;
        // s and r both set is reserved: always denied
        if (!(sys_prot && rom_prot)) begin
            case (ap)
                2'h0: allow = !write && ((sys_prot && !user) || rom_prot);
                2'h1: allow = !user;
                2'h2: allow = !user || !write;
                2'h3: allow = 1'b1;
                default: allow = 1'b0;
            endcase
        end
    end
endmodule

// ### logic/mmu_fault_checker.sv
`timescale 1ns/1ns
module mmu_fault_checker
    import mmu_fault_pkg::*;
#(
    parameter int LINE_WORDS = LINE_WORDS_DEFAULT
)
(
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // control
    input wire logic [31:0] SYS_CTRL,
    input wire logic [31:0] DOMAIN_ACCESS,
    input wire logic [17:0] TABLE_BASE,
    // core access
    input wire logic ACC_VALID,
    input wire acc_req_t ACC_REQ,
    output logic ACC_READY,
    output logic ACC_DONE,
    output logic DATA_ABORT_SIGNAL,
    output logic FETCH_ABORT_FLAG,
    output logic [3:0] FAULT_STATUS_CODE,
    output logic [3:0] FAULT_DOMAIN,
    output logic LINE_INVALIDATE,
    // descriptor fetch
    output logic DESC_REQ,
    output logic [31:0] DESC_ADDR,
    input wire logic DESC_ACK,
    input wire logic [31:0] DESC_RDATA,
    input wire logic DESC_ABORT,
    // memory bus
    output logic MEM_REQ,
    output logic MEM_WRITE,
    output logic MEM_LINE,
    output logic [31:0] MEM_ADDR,
    input wire logic MEM_ACK,
    input wire logic MEM_ABORT
);
    localparam int WB = $clog2(LINE_WORDS);

    // refused at elaboration: the word counter and line address need a power of two
    if (LINE_WORDS < 2 || LINE_WORDS > 16 || (1 << WB) != LINE_WORDS) begin : line_words_check
        $error("LINE_WORDS must be a power of two from 2 to 16");
    end

    state_t state_reg;
    state_t state_next;
    acc_req_t req_reg;
    logic [31:0] l1_reg;
    logic page_reg;
    logic [WB-1:0] word_cnt_reg;
    logic line_bad_reg;
    logic line_abort_reg;
    logic fin;
    logic [3:0] fin_code;
    logic [31:0] pa_next;
    logic accept;
    logic misaligned;
    logic mmu_on;
    logic [3:0] dom_num;
    logic [1:0] dom_field;
    logic [1:0] ap_sel;
    logic allow;
    logic [3:0] dom_perm_code;
    logic [WB-1:0] req_word;
    logic line_last;

    function automatic logic [1:0] subpage_ap(input logic [31:0] d, input logic [31:0] va);
        logic [1:0] sel;
        sel = 2'h0;
        case (d[1:0])
            L2_LARGE: sel = va[15:14];
            L2_SMALL: sel = va[11:10];
            default: sel = 2'h0;
        endcase
        subpage_ap = d[5'(L2_AP_LSB) + 5'({sel, 1'b0}) +: 2];
    endfunction

    // bus address: aligned when unchecked misaligned accesses go out
    function automatic logic [31:0] bus_addr(input logic [31:0] pa, input acc_req_t r);
        logic [31:0] a;
        a = pa;
        if (r.linefill) begin
            a = {pa[31:WB+2], {(WB + 2){1'b0}}};
        end else if (!r.write || r.size == SZ_WORD) begin
            a = {pa[31:2], 2'h0};
        end else if (r.size == SZ_HALF) begin
            a = {pa[31:1], 1'b0};
        end
        bus_addr = a;
    endfunction

    assign accept = ACC_VALID && ACC_READY;
    assign ACC_READY = (state_reg == ST_IDLE);
    assign mmu_on = SYS_CTRL[CTRL_MMU_BIT];
    assign misaligned = SYS_CTRL[CTRL_ALIGN_BIT] && !ACC_REQ.fetch &&
        ((ACC_REQ.size == SZ_HALF && ACC_REQ.va[0]) ||
         (ACC_REQ.size == SZ_WORD && ACC_REQ.va[1:0] != 2'h0));

    assign dom_num = (state_reg == ST_L1) ? DESC_RDATA[L1_DOMAIN_LSB +: 4]
                                          : l1_reg[L1_DOMAIN_LSB +: 4];
    assign dom_field = DOMAIN_ACCESS[5'({dom_num, 1'b0}) +: 2];
    assign ap_sel = (state_reg == ST_L1) ? DESC_RDATA[L1_AP_LSB +: 2]
                                         : subpage_ap(DESC_RDATA, req_reg.va);

    perm_decode perm_u (
        .ap(ap_sel),
        .sys_prot(SYS_CTRL[CTRL_SYS_BIT]),
        .rom_prot(SYS_CTRL[CTRL_ROM_BIT]),
        .user(req_reg.user),
        .write(req_reg.write && !req_reg.swap),
        .allow(allow)
    );

    always_comb begin
        dom_perm_code = FS_NONE;
        if (dom_field == DOM_NO_ACCESS || dom_field == DOM_RESERVED) begin
            dom_perm_code = page_reg ? FS_DOM_PAGE : FS_DOM_SEC;
        end else if (dom_field == DOM_CLIENT && !allow) begin
            dom_perm_code = page_reg ? FS_PERM_PAGE : FS_PERM_SEC;
        end
    end

    assign req_word = req_reg.va[WB+1:2];
    assign line_last = (word_cnt_reg == WB'(LINE_WORDS - 1));

    // checks run in order before the bus
    // first fault found ends the access, except a bus abort in a line fill, which runs to its last word
    always_comb begin
        state_next = state_reg;
        fin = 1'b0;
        fin_code = FS_NONE;
        pa_next = ACC_REQ.va;
        case (state_reg)
            ST_IDLE: begin
                if (accept) begin
                    if (misaligned) begin
                        fin = 1'b1;
                        fin_code = FS_ALIGN;
                    end else if (!mmu_on) begin
                        state_next = ST_BUS;
                    end else begin
                        state_next = ST_L1;
                    end
                end
            end
            ST_L1: begin
                pa_next = {DESC_RDATA[31:20], req_reg.va[19:0]};
                if (DESC_ACK) begin
                    if (DESC_ABORT) begin
                        fin = 1'b1;
                        fin_code = FS_EXT_L1;
                    end else if (DESC_RDATA[1:0] == DESC_INVALID) begin
                        fin = 1'b1;
                        fin_code = FS_TRANS_SEC;
                    end else if (DESC_RDATA[1:0] == L1_SECTION) begin
                        fin = (dom_perm_code != FS_NONE);
                        fin_code = dom_perm_code;
                        state_next = fin ? ST_IDLE : ST_BUS;
                    end else begin
                        state_next = ST_L2;
                    end
                    if (fin) begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_L2: begin
                case (DESC_RDATA[1:0])
                    L2_LARGE: pa_next = {DESC_RDATA[31:16], req_reg.va[15:0]};
                    L2_SMALL: pa_next = {DESC_RDATA[31:12], req_reg.va[11:0]};
                    default: pa_next = {DESC_RDATA[31:10], req_reg.va[9:0]};
                endcase
                if (DESC_ACK) begin
                    if (DESC_ABORT) begin
                        fin = 1'b1;
                        fin_code = FS_EXT_L2;
                    end else if (DESC_RDATA[1:0] == DESC_INVALID) begin
                        fin = 1'b1;
                        fin_code = FS_TRANS_PAGE;
                    end else begin
                        fin = (dom_perm_code != FS_NONE);
                        fin_code = dom_perm_code;
                    end
                    state_next = fin ? ST_IDLE : ST_BUS;
                end
            end
            ST_BUS: begin
                if (MEM_ACK) begin
                    if (req_reg.linefill) begin
                        if (line_last) begin
                            fin = 1'b1;
                            if (line_abort_reg || (MEM_ABORT && word_cnt_reg <= req_word)) begin
                                fin_code = page_reg ? FS_LINE_PAGE : FS_LINE_SEC;
                            end
                            state_next = ST_IDLE;
                        end
                    end else if (MEM_ABORT) begin
                        fin = 1'b1;
                        fin_code = page_reg ? FS_NCNB_PAGE : FS_NCNB_SEC;
                        state_next = ST_IDLE;
                    // write phase only after clean read
                    end else if (req_reg.swap) begin
                        state_next = ST_SWAP_WR;
                    end else begin
                        fin = 1'b1;
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_SWAP_WR: begin
                if (MEM_ACK) begin
                    fin = 1'b1;
                    if (MEM_ABORT) begin
                        fin_code = page_reg ? FS_NCNB_PAGE : FS_NCNB_SEC;
                    end
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            req_reg <= '0;
            l1_reg <= 32'h0;
            page_reg <= 1'b0;
        end else begin
            if (accept) begin
                req_reg <= ACC_REQ;
                page_reg <= 1'b0;
            end
            if (state_reg == ST_L1 && DESC_ACK) begin
                l1_reg <= DESC_RDATA;
                page_reg <= (DESC_RDATA[1:0] == L1_COARSE || DESC_RDATA[1:0] == L1_FINE);
            end
        end
    end

    // descriptor address: table base, then coarse or fine table
    always_ff @(posedge CLK) begin
        if (RESET) begin
            DESC_ADDR <= 32'h0;
        end else if (accept) begin
            DESC_ADDR <= {TABLE_BASE, ACC_REQ.va[31:20], 2'h0};
        end else if (state_reg == ST_L1 && DESC_ACK) begin
            if (DESC_RDATA[1:0] == L1_FINE) begin
                DESC_ADDR <= {DESC_RDATA[31:12], req_reg.va[19:10], 2'h0};
            end else begin
                DESC_ADDR <= {DESC_RDATA[31:10], req_reg.va[19:12], 2'h0};
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            MEM_ADDR <= 32'h0;
        end else if (state_next == ST_BUS && state_reg != ST_BUS) begin
            MEM_ADDR <= bus_addr(pa_next, (state_reg == ST_IDLE) ? ACC_REQ : req_reg);
        end
    end

    // line fill word tracking
    always_ff @(posedge CLK) begin
        if (RESET || state_reg != ST_BUS) begin
            word_cnt_reg <= '0;
            line_bad_reg <= 1'b0;
            line_abort_reg <= 1'b0;
        end else if (MEM_ACK && req_reg.linefill) begin
            word_cnt_reg <= word_cnt_reg + WB'(1);
            if (MEM_ABORT) begin
                line_bad_reg <= 1'b1;
                if (word_cnt_reg <= req_word) begin
                    line_abort_reg <= 1'b1;
                end
            end
        end
    end

    // fetch faults only flag the instruction
    always_ff @(posedge CLK) begin
        if (RESET) begin
            ACC_DONE <= 1'b0;
            DATA_ABORT_SIGNAL <= 1'b0;
            FETCH_ABORT_FLAG <= 1'b0;
            LINE_INVALIDATE <= 1'b0;
            FAULT_STATUS_CODE <= FS_NONE;
            FAULT_DOMAIN <= 4'h0;
        end else begin
            ACC_DONE <= fin;
            // in idle the held request is stale, so the incoming one decides
            DATA_ABORT_SIGNAL <= fin && fin_code != FS_NONE &&
                !(state_reg == ST_IDLE ? ACC_REQ.fetch : req_reg.fetch);
            FETCH_ABORT_FLAG <= fin && fin_code != FS_NONE &&
                (state_reg == ST_IDLE ? ACC_REQ.fetch : req_reg.fetch);
            LINE_INVALIDATE <= fin && req_reg.linefill && state_reg == ST_BUS &&
                (line_bad_reg || MEM_ABORT);
            // status kept for data aborts only
            if (fin && fin_code != FS_NONE && !(state_reg == ST_IDLE ? ACC_REQ.fetch
                                                                     : req_reg.fetch)) begin
                FAULT_STATUS_CODE <= fin_code;
                FAULT_DOMAIN <= dom_num;
            end
        end
    end

    // only the swap's second phase and plain writes drive a write
    assign DESC_REQ = (state_reg == ST_L1) || (state_reg == ST_L2);
    assign MEM_REQ = (state_reg == ST_BUS) || (state_reg == ST_SWAP_WR);
    assign MEM_WRITE = (state_reg == ST_SWAP_WR) ||
        (state_reg == ST_BUS && req_reg.write && !req_reg.swap && !req_reg.linefill);
    assign MEM_LINE = (state_reg == ST_BUS) && req_reg.linefill;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    align_fault_a: assert property (accept && misaligned |=>
        DATA_ABORT_SIGNAL && FAULT_STATUS_CODE == FS_ALIGN) else $error("alignment fault missed");
    align_unmapped_a: assert property (accept && misaligned && !mmu_on |=>
        state_reg == ST_IDLE && ACC_DONE) else $error("unmapped alignment fault missed");
    fetch_no_align_a: assert property (accept && ACC_REQ.fetch && !mmu_on |=>
        MEM_REQ && !FETCH_ABORT_FLAG) else $error("fetch was alignment checked");
    align_skip_a: assert property (accept && misaligned |=> !DESC_REQ && !MEM_REQ)
        else $error("checks ran after alignment fault");
    write_align_a: assert property (MEM_WRITE && req_reg.size == SZ_WORD |->
        MEM_ADDR[1:0] == 2'h0) else $error("word write not aligned");
    sec_trans_a: assert property (state_reg == ST_L1 && DESC_ACK && !DESC_ABORT &&
        DESC_RDATA[1:0] == DESC_INVALID |=> ACC_DONE && !MEM_REQ &&
        (req_reg.fetch || FAULT_STATUS_CODE == FS_TRANS_SEC)) else $error("section fault missed");
    page_trans_a: assert property (state_reg == ST_L2 && DESC_ACK && !DESC_ABORT &&
        DESC_RDATA[1:0] == DESC_INVALID |=> ACC_DONE &&
        (req_reg.fetch || FAULT_STATUS_CODE == FS_TRANS_PAGE)) else $error("page fault missed");
    domain_fault_a: assert property (state_reg == ST_L1 && DESC_ACK && !DESC_ABORT &&
        DESC_RDATA[1:0] == L1_SECTION && !dom_field[0] |=> ACC_DONE && !MEM_REQ)
        else $error("domain fault missed");
    manager_a: assert property (state_reg == ST_L1 && DESC_ACK && !DESC_ABORT &&
        DESC_RDATA[1:0] == L1_SECTION && dom_field == DOM_MANAGER |=> MEM_REQ ##0 !ACC_DONE)
        else $error("manager access was checked");
    swap_suppress_a: assert property (state_reg == ST_BUS && req_reg.swap &&
        !req_reg.linefill && MEM_ACK && MEM_ABORT |=> !MEM_REQ [*2])
        else $error("swap write after aborted read");
    line_inval_a: assert property (LINE_INVALIDATE |-> ACC_DONE)
        else $error("invalidate outside completion");

    section_ok_c: cover property (state_reg == ST_L1 && DESC_ACK ##1 state_reg == ST_BUS);
    page_ok_c: cover property (state_reg == ST_L2 && DESC_ACK ##1 state_reg == ST_BUS);
    line_abort_c: cover property (LINE_INVALIDATE && DATA_ABORT_SIGNAL);
    swap_c: cover property (state_reg == ST_SWAP_WR && MEM_ACK);
endmodule

// ### verification/mem_partner.sv
`timescale 1ns/1ns
module mem_partner (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // setup from the bench
    input wire logic [31:0] l1_word,
    input wire logic [31:0] l2_word,
    input wire logic [4:0] abort_at,
    input wire logic slow,
    // descriptor port
    input wire logic desc_req,
    input wire logic [31:0] desc_addr,
    output logic desc_ack,
    output logic [31:0] desc_rdata,
    output logic desc_abort,
    // bus port
    input wire logic mem_req,
    input wire logic mem_write,
    output logic mem_ack,
    output logic mem_abort
);
    logic [1:0] wait_reg;
    logic [4:0] word_reg;
    logic go;

    // slow mode holds each answer back two cycles
    assign go = (desc_req || mem_req) && !desc_ack && !mem_ack && (!slow || wait_reg == 2'h2);

    always_ff @(posedge clk) begin
        if (reset || desc_ack || mem_ack) begin
            wait_reg <= 2'h0;
        end else if (desc_req || mem_req) begin
            wait_reg <= wait_reg + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || !mem_req) begin
            word_reg <= 5'h0;
        end else if (mem_ack) begin
            word_reg <= word_reg + 5'h1;
        end
    end

    always_ff @(posedge clk) begin
        desc_ack <= !reset && desc_req && go;
        mem_ack <= !reset && mem_req && go;
        // abort setting 10 fails every descriptor fetch
        desc_abort <= !reset && desc_req && go && abort_at == 5'h10;
        mem_abort <= !reset && mem_req && go && !mem_write && word_reg == abort_at;
        // released data lines flip so a stale value is never mistaken for data
        if (reset) begin
            desc_rdata <= 32'h0;
        end else if (desc_req && go) begin
            desc_rdata <= (desc_addr < 32'h0001_0000) ? l1_word : l2_word;
        end else begin
            desc_rdata <= ~desc_rdata;
        end
    end
endmodule

// ### verification/test_mmu_fault_checker.sv
`timescale 1ns/1ns
module test_mmu_fault_checker;
    import mmu_fault_pkg::*;
    localparam logic [4:0] f_rd = 5'h00;
    localparam logic [4:0] f_wr = 5'h10;
    localparam logic [4:0] f_fetch = 5'h08;
    localparam logic [4:0] f_swap = 5'h02;
    localparam logic [4:0] f_line = 5'h01;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic [31:0] SYS_CTRL = 32'h0;
    logic [31:0] DOMAIN_ACCESS = 32'h0;
    logic [17:0] TABLE_BASE = 18'h00001;
    logic ACC_VALID = 1'b0;
    acc_req_t ACC_REQ = '0;
    logic ACC_READY, ACC_DONE, DATA_ABORT_SIGNAL, FETCH_ABORT_FLAG, LINE_INVALIDATE;
    logic [3:0] FAULT_STATUS_CODE, FAULT_DOMAIN;
    logic DESC_REQ, DESC_ACK, DESC_ABORT, MEM_REQ, MEM_WRITE, MEM_LINE, MEM_ACK, MEM_ABORT;
    logic [31:0] DESC_ADDR, DESC_RDATA, MEM_ADDR, mem_addr;
    logic [31:0] l1 = 32'h0;
    logic [31:0] l2 = 32'h0;
    logic [4:0] abort_at = 5'h1F;
    logic slow = 1'b0;
    logic seen_mem, seen_wr, seen_desc, seen_line, ab, fa, li;
    int n_errors = 0;
    int compares = 0;

    mmu_fault_checker #(.LINE_WORDS(8)) DUT (.CLK(CLK), .RESET(RESET), .SYS_CTRL(SYS_CTRL),
        .DOMAIN_ACCESS(DOMAIN_ACCESS), .TABLE_BASE(TABLE_BASE), .ACC_VALID(ACC_VALID),
        .ACC_REQ(ACC_REQ), .ACC_READY(ACC_READY), .ACC_DONE(ACC_DONE),
        .DATA_ABORT_SIGNAL(DATA_ABORT_SIGNAL), .FETCH_ABORT_FLAG(FETCH_ABORT_FLAG),
        .FAULT_STATUS_CODE(FAULT_STATUS_CODE), .FAULT_DOMAIN(FAULT_DOMAIN),
        .LINE_INVALIDATE(LINE_INVALIDATE), .DESC_REQ(DESC_REQ), .DESC_ADDR(DESC_ADDR),
        .DESC_ACK(DESC_ACK), .DESC_RDATA(DESC_RDATA), .DESC_ABORT(DESC_ABORT),
        .MEM_REQ(MEM_REQ), .MEM_WRITE(MEM_WRITE), .MEM_LINE(MEM_LINE), .MEM_ADDR(MEM_ADDR),
        .MEM_ACK(MEM_ACK), .MEM_ABORT(MEM_ABORT));

    mem_partner far_end (.clk(CLK), .reset(RESET), .l1_word(l1), .l2_word(l2),
        .abort_at(abort_at), .slow(slow), .desc_req(DESC_REQ), .desc_addr(DESC_ADDR),
        .desc_ack(DESC_ACK), .desc_rdata(DESC_RDATA), .desc_abort(DESC_ABORT),
        .mem_req(MEM_REQ), .mem_write(MEM_WRITE), .mem_ack(MEM_ACK), .mem_abort(MEM_ABORT));

    always #2 CLK = ~CLK;

    // first bus address and any write or walk seen during one access
    always @(posedge CLK) begin
        if (MEM_REQ === 1'b1 && !seen_mem) begin
            mem_addr = MEM_ADDR;
            seen_mem = 1'b1;
        end
        if (MEM_REQ === 1'b1 && MEM_WRITE === 1'b1) seen_wr = 1'b1;
        if (DESC_REQ === 1'b1) seen_desc = 1'b1;
        if (MEM_LINE === 1'b1) seen_line = 1'b1;
    end

    task automatic report_and_stop();
        $display("n_errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one access, taken at once since the block is idle; ends at the done pulse
    task automatic acc(input logic [31:0] va, input logic [1:0] sz, input logic [4:0] fl);
        int i;
        @(negedge CLK);
        ACC_REQ = acc_req_t'({va, sz, fl});
        ACC_VALID = 1'b1;
        seen_mem = 1'b0;
        seen_wr = 1'b0;
        seen_desc = 1'b0;
        seen_line = 1'b0;
        mem_addr = 32'hFFFF_FFFF;
        @(negedge CLK);
        ACC_VALID = 1'b0;
        for (i = 0; i < 200 && ACC_DONE !== 1'b1; i++) @(negedge CLK);
        if (i == 200) begin
            n_errors++;
            report_and_stop();
        end
        ab = DATA_ABORT_SIGNAL;
        fa = FETCH_ABORT_FLAG;
        li = LINE_INVALIDATE;
    endtask

    task automatic s_align();
        int m;
        l1 = 32'h0;
        for (m = 0; m < 2; m++) begin
            SYS_CTRL = 32'h2 | 32'(m);
            acc(32'h0030_0101, SZ_HALF, f_wr);
            chk({ab, FAULT_STATUS_CODE, seen_desc, seen_mem}, {1'h1, FS_ALIGN, 2'h0});
            acc(32'h0030_0102, SZ_WORD, f_rd);
            chk({ab, FAULT_STATUS_CODE, seen_desc, seen_mem}, {1'h1, FS_ALIGN, 2'h0});
            // fetch faults only flag and keep the status
            acc(32'h0030_0102, SZ_WORD, f_fetch);
            chk({ab, fa, FAULT_STATUS_CODE}, {1'h0, 1'(m), FS_ALIGN});
        end
    endtask

    task automatic s_plain();
        SYS_CTRL = 32'h0;
        acc(32'h0000_0107, SZ_WORD, f_rd);
        chk({ab, mem_addr}, {1'h0, 32'h0000_0104});
        acc(32'h0000_0107, SZ_HALF, f_wr);
        chk({ab, mem_addr}, {1'h0, 32'h0000_0106});
        acc(32'h0030_0010, SZ_WORD, f_rd);
        chk({ab, seen_desc, mem_addr}, {2'h0, 32'h0030_0010});
    endtask

    task automatic s_section();
        int d;
        SYS_CTRL = 32'h1;
        l1 = 32'h0;
        acc(32'h0030_0010, SZ_WORD, f_rd);
        chk({ab, FAULT_STATUS_CODE}, {1'h1, FS_TRANS_SEC});
        l1 = 32'h0050_0062;
        // every domain field value against permission bits 00
        for (d = 0; d < 4; d++) begin
            DOMAIN_ACCESS = 32'(d) << 6;
            acc(32'h0030_0010, SZ_WORD, f_rd);
            chk({ab, FAULT_STATUS_CODE, FAULT_DOMAIN, seen_mem}, {d != 3,
                (d == 1) ? FS_PERM_SEC : FS_DOM_SEC, 4'h3, d == 3});
        end
        chk(mem_addr, 32'h0050_0010);
        DOMAIN_ACCESS = 32'h40;
        SYS_CTRL = 32'h101;
        acc(32'h0030_0010, SZ_WORD, f_rd);
        chk({ab, mem_addr}, {1'h0, 32'h0050_0010});
    endtask

    task automatic s_page();
        SYS_CTRL = 32'h1;
        DOMAIN_ACCESS = 32'h40;
        slow = 1'b1;
        l1 = 32'h0010_0061;
        l2 = 32'h0;
        acc(32'h0030_0C00, SZ_WORD, f_rd);
        chk({ab, FAULT_STATUS_CODE}, {1'h1, FS_TRANS_PAGE});
        l2 = 32'h0070_0CF2;
        acc(32'h0030_0800, SZ_WORD, f_rd);
        chk({ab, FAULT_STATUS_CODE}, {1'h1, FS_PERM_PAGE});
        acc(32'h0030_0C00, SZ_WORD, f_rd);
        chk({ab, mem_addr}, {1'h0, 32'h0070_0C00});
        DOMAIN_ACCESS = 32'h0;
        acc(32'h0030_0C00, SZ_WORD, f_rd);
        chk({ab, FAULT_STATUS_CODE}, {1'h1, FS_DOM_PAGE});
        slow = 1'b0;
    endtask

    task automatic s_ext();
        SYS_CTRL = 32'h0;
        abort_at = 5'h0;
        acc(32'h0000_0200, SZ_WORD, f_swap);
        chk({ab, seen_wr}, {1'h1, 1'h0});
        abort_at = 5'h1F;
        acc(32'h0000_0200, SZ_WORD, f_swap);
        chk({ab, seen_wr}, {1'h0, 1'h1});
        // abort after, on and never against requested word 2
        abort_at = 5'h5;
        acc(32'h0000_0308, SZ_WORD, f_line);
        chk({ab, li, seen_line, mem_addr}, {3'h3, 32'h0000_0300});
        abort_at = 5'h2;
        acc(32'h0000_0308, SZ_WORD, f_line);
        chk({ab, li, seen_line, mem_addr}, {3'h7, 32'h0000_0300});
        abort_at = 5'h1F;
        acc(32'h0000_0308, SZ_WORD, f_line);
        chk({ab, li}, {2'h0});
        // failing first-level fetch outranks the coarse table descriptor behind it
        SYS_CTRL = 32'h1;
        abort_at = 5'h10;
        acc(32'h0030_0010, SZ_WORD, f_rd);
        chk({ab, FAULT_STATUS_CODE, seen_mem}, {1'h1, FS_EXT_L1, 1'h0});
        abort_at = 5'h1F;
    endtask

    initial begin
        repeat (4) @(posedge CLK);
        @(negedge CLK);
        RESET = 1'b0;
        s_align();
        s_plain();
        s_section();
        s_page();
        s_ext();
        report_and_stop();
    end
endmodule
